// *** hw/vdd_chroma_decim.sv ***
// Two-channel 2:1 chroma decimation filter with equal-latency bypass
`timescale 1ns/1ns
module vdd_chroma_decim
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Chroma stream
  vdd_filt_if.filt fi
);
  import vdd_pkg::*;

  logic vld_d_r;
  logic phase_r;
  logic strobe_r;
  logic filt_r;
  logic filt_on;

  assign filt_on = fi.decim & ~fi.bypass;
  assign fi.out_strobe = strobe_r;

  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
      vdd_samp_t src;
      vdd_samp_t tap_r [3];
      vdd_samp_t res_r;
      logic signed [31:0] sum;
      logic signed [31:0] rnd;
      assign src = (c == 0) ? fi.cb_in : fi.cr_in;
      // 1-2-1 kernel centred on the middle tap, two fractional bits
      assign sum = 32'(tap_r[0]) + (32'(tap_r[1]) <<< 1) + 32'(tap_r[2]);
      assign rnd = fi.narrow ? ((sum + FILT_HALF_N) >>> FILT_SH_N)
                             : ((sum + FILT_HALF_W) >>> FILT_SH_W);
      if (c == 0)
      begin : g_b
        assign fi.cb_out = res_r;
      end
      else
      begin : g_r
        assign fi.cr_out = res_r;
      end
      always_ff @(posedge clock_i)
      begin
        if (!reset_n_i)
          tap_r <= '{default: '0};
        else if (fi.in_valid)
        begin
          tap_r[0] <= src;
          tap_r[1] <= tap_r[0];
          tap_r[2] <= tap_r[1];
        end
      end
      always_ff @(posedge clock_i)
      begin
        if (!reset_n_i)
          res_r <= '0;
        else if (vld_d_r)
        begin
          if (!filt_on)
            res_r <= tap_r[1];
          else if (fi.narrow)
            res_r <= {vdd_sat11(rnd), 2'h0};
          else
            res_r <= vdd_sat13(rnd);
        end
      end
    end
  endgenerate

  // Decimation keeps every other filtered sample, co-sited pairs
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      vld_d_r <= 1'b0;
      phase_r <= 1'b0;
      strobe_r <= 1'b0;
      filt_r <= 1'b0;
    end
    else
    begin
      vld_d_r <= fi.in_valid;
      strobe_r <= vld_d_r & (~filt_on | ~phase_r);
      filt_r <= filt_on;
      if (vld_d_r)
        phase_r <= filt_on & ~phase_r;
    end
  end

  sequence bypass_run_s;
    fi.bypass && fi.in_valid ##1 fi.bypass && fi.in_valid ##1 fi.bypass;
  endsequence

  bypass_pass_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    bypass_run_s |=> fi.cb_out == $past(fi.cb_in, 3))
    else $error("Bypassed chroma differs from input");

  decim_alternate_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    strobe_r && filt_r |=> !strobe_r || !filt_r)
    else $error("Decimated strobe on two cycles in a row");

  narrow_round_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    strobe_r && filt_r && $past(fi.narrow)
      |-> fi.cb_out[1:0] == 2'h0 && fi.cr_out[1:0] == 2'h0)
    else $error("Narrow filter output keeps low bits");
endmodule : vdd_chroma_decim

// *** hw/vdd_decim_core.sv ***
// Decimation-mode processing core: matrix, rounding, chroma filter, delay
// Operation
// - Input layout unaffected by sync flag option
// - Matrix keeps full precision, rounds outputs only
// - Width bit 0: 10-bit core, 2 LSB
// - Width 1, filter on: keep LSB extensions
// - Width 1, bypass: drop LSB extensions
// - Decimate mode halves both chroma channels
// - Filter output 13 or 11 bits
// - Chroma filter rounds to 13 or 11
// - Bypass bit passes chroma unmodified
// - Same latency with or without bypass
// - Latency 68 dual link, 136 single
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module vdd_decim_core
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [vdd_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Video input
  input wire logic sample_valid_i,
  input wire vdd_pkg::vdd_samp_t second_side_port_a_i,
  input wire vdd_pkg::vdd_samp_t second_side_port_b_i,
  input wire vdd_pkg::vdd_samp_t second_side_port_c_i,
  input wire vdd_pkg::vdd_key_t second_side_key_port_i,
  // Video output
  output logic out_valid_o,
  output logic chroma_strobe_o,
  output vdd_pkg::vdd_samp_t luma_o,
  output vdd_pkg::vdd_samp_t chroma_b_o,
  output vdd_pkg::vdd_samp_t chroma_r_o,
  output vdd_pkg::vdd_key_t key_o,
  // Status and configuration
  output logic settled_o,
  output logic sync_flag_output_enable_o
);
  import vdd_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] cfg_prev_r;
  logic [CTRL_W-1:0] ctrl_wdata;
  logic [COEF_W-1:0] coef_r [NUM_COEF];
  logic [31:0] prdata_r;
  logic [31:0] rd_word;
  logic pslverr_r;
  logic wr_en;
  logic coef_hit;
  logic mapped;
  logic [ADDR_W-1:0] coef_off;
  logic [3:0] coef_idx;
  logic [7:0] settle_cnt_r;
  logic settled_r;
  logic interp_decim_select;
  logic round_width_select;
  logic bypass_on;
  logic ss_in;
  logic single;
  logic heavy;

  assign interp_decim_select = ctrl_r[CTL_INTERP];
  assign round_width_select = ctrl_r[CTL_RND];
  assign bypass_on = ctrl_r[CTL_BYPASS];
  assign ss_in = ctrl_r[CTL_SSIN];
  assign single = ctrl_r[CTL_SINGLE];
  assign heavy = round_width_select & bypass_on;
  assign sync_flag_output_enable_o = ctrl_r[CTL_SYNC];

  // APB decode; zero wait states, read data captured in setup
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = pslverr_r & pready_o;
  assign prdata_o = prdata_r;
  assign ctrl_wdata = pwdata_i[CTRL_W-1:0];
  assign coef_off = paddr_i - ADDR_COEF;
  assign coef_idx = coef_off[5:2];
  assign coef_hit = (paddr_i >= ADDR_COEF) && (paddr_i <= ADDR_KEYC)
                    && (paddr_i[1:0] == 2'h0);
  assign mapped = coef_hit || (paddr_i == ADDR_CTRL)
                  || (paddr_i == ADDR_STATUS);

  always_comb
  begin
    rd_word = 32'h0;
    if (paddr_i == ADDR_CTRL)
      rd_word = 32'(ctrl_r);
    else if (paddr_i == ADDR_STATUS)
      rd_word = 32'({settle_cnt_r, settled_r});
    else if (coef_hit)
      rd_word = 32'(coef_r[coef_idx]);
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      prdata_r <= rd_word;
      pslverr_r <= ~mapped;
    end
  end

  // Static configuration, used by the datapath from the next cycle
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      ctrl_r <= CTRL_RESET;
    else if (wr_en && paddr_i == ADDR_CTRL)
      ctrl_r <= ctrl_wdata;
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_COEF; i++)
        coef_r[i] <= COEF_UNITY[i] ? COEF_ONE : COEF_ZERO;
    end
    else if (wr_en && coef_hit)
      coef_r[coef_idx] <= pwdata_i[COEF_W-1:0];
  end

  // Any control register change restarts a full-latency settle period
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      cfg_prev_r <= CTRL_RESET;
      settle_cnt_r <= SETTLE_DUAL;
      settled_r <= 1'b0;
    end
    else
    begin
      cfg_prev_r <= ctrl_r;
      if (ctrl_r != cfg_prev_r)
      begin
        settle_cnt_r <= single ? SETTLE_SINGLE : SETTLE_DUAL;
        settled_r <= 1'b0;
      end
      else if (settle_cnt_r != 8'h0)
      begin
        settle_cnt_r <= settle_cnt_r - 8'h1;
        settled_r <= (settle_cnt_r == 8'h1);
      end
    end
  end
  assign settled_o = settled_r;

  // Stage 1: input capture, layout independent of the sync flag option
  vdd_samp_t in_r [3];
  logic signed [KEY_W:0] key_r;
  logic v1_r;

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      in_r <= '{default: '0};
      key_r <= '0;
      v1_r <= 1'b0;
    end
    else
    begin
      v1_r <= sample_valid_i;
      in_r[0] <= ss_in ? second_side_port_a_i : '0;
      in_r[1] <= ss_in ? second_side_port_b_i : '0;
      in_r[2] <= ss_in ? second_side_port_c_i : '0;
      if (!ss_in)
        key_r <= '0;
      else if (round_width_select)
        key_r <= {1'b0, second_side_key_port_i};
      else
        key_r <= {second_side_key_port_i[KEY_W-1],
                  second_side_key_port_i};
    end
  end

  // Stages 2 and 3: full precision matrix, then output rounding
  logic signed [31:0] acc_nxt [3];
  logic signed [31:0] acc_r [3];
  logic signed [31:0] key_acc_r;
  vdd_samp_t mat_nxt [3];
  vdd_samp_t mat_r [3];
  vdd_key_t keym_r;
  logic v2_r;
  logic v3_r;

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_row
      logic signed [31:0] rw;
      logic signed [31:0] rn;
      // No rounding inside the sum of products
      assign acc_nxt[i] = 32'(in_r[0]) * 32'($signed(coef_r[3 * i]))
                        + 32'(in_r[1]) * 32'($signed(coef_r[3 * i + 1]))
                        + 32'(in_r[2]) * 32'($signed(coef_r[3 * i + 2]));
      assign rw = (acc_r[i] + MAT_HALF_W) >>> MAT_SH_W;
      assign rn = (acc_r[i] + MAT_HALF_N) >>> MAT_SH_N;
      // Heavy rounding drops the LSB extension bits
      assign mat_nxt[i] = heavy ? {vdd_sat11(rn), 2'h0}
                                : vdd_sat13(rw);
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      acc_r <= '{default: '0};
      mat_r <= '{default: '0};
      key_acc_r <= '0;
      keym_r <= '0;
      v2_r <= 1'b0;
      v3_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      mat_r <= mat_nxt;
      key_acc_r <= 32'(key_r) * 32'($signed(coef_r[KEY_IDX]));
      keym_r <= vdd_sat11((key_acc_r + MAT_HALF_W) >>> MAT_SH_W);
      v2_r <= v1_r;
      v3_r <= v2_r;
    end
  end

  // Chroma filter; luma and key take the same two stages alongside
  vdd_filt_if fif ();
  assign fif.cb_in = mat_r[1];
  assign fif.cr_in = mat_r[2];
  assign fif.in_valid = v3_r;
  assign fif.bypass = bypass_on;
  assign fif.decim = ~interp_decim_select;
  assign fif.narrow = round_width_select;

  vdd_chroma_decim u_filt (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .fi(fif.filt)
  );

  vdd_samp_t y_d_r [2];
  vdd_key_t k_d_r [2];
  logic [1:0] v_d_r;

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      y_d_r <= '{default: '0};
      k_d_r <= '{default: '0};
      v_d_r <= 2'h0;
    end
    else
    begin
      y_d_r[0] <= mat_r[0];
      y_d_r[1] <= y_d_r[0];
      k_d_r[0] <= keym_r;
      k_d_r[1] <= k_d_r[0];
      v_d_r <= {v_d_r[0], v3_r};
    end
  end

  // Delay line pads the pipeline to the documented fixed latency
  vdd_word_t dl_in;
  vdd_word_t tap_word;
  vdd_word_t out_r;
  vdd_word_t [DL_MAX-1:0] dl_r;

  assign dl_in = '{valid: v_d_r[1], strobe: fif.out_strobe,
                   y: y_d_r[1], cb: fif.cb_out, cr: fif.cr_out,
                   key: k_d_r[1]};
  assign tap_word = single ? dl_r[LAT_SINGLE - PIPE_FIXED]
                           : dl_r[LAT_DUAL - PIPE_FIXED];

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      dl_r <= '0;
      out_r <= '0;
    end
    else
    begin
      dl_r <= {dl_r[DL_MAX-2:0], dl_in};
      out_r <= tap_word;
    end
  end

  assign out_valid_o = out_r.valid;
  assign chroma_strobe_o = out_r.strobe;
  assign luma_o = out_r.y;
  assign chroma_b_o = out_r.cb;
  assign chroma_r_o = out_r.cr;
  assign key_o = out_r.key;

  latency_dual_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    sample_valid_i && settled_r && !single
      |-> ##68 (out_valid_o || !settled_r))
    else $error("Dual link latency is not 68 cycles");

  latency_single_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    sample_valid_i && settled_r && single
      |-> ##136 (out_valid_o || !settled_r))
    else $error("Single link latency is not 136 cycles");

  matrix_heavy_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    heavy |=> (mat_r[0][1:0] | mat_r[1][1:0] | mat_r[2][1:0]) == 2'h0)
    else $error("Heavy matrix rounding keeps LSB extensions");

  settle_hold_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    $changed(bypass_on) |=> !settled_r [*8])
    else $error("Settled flag not cleared after bypass change");

  ctrl_update_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_en && paddr_i == ADDR_CTRL |=> ctrl_r == $past(ctrl_wdata))
    else $error("Control write not applied next cycle");

  input_layout_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    ss_in |=> in_r[0] == $past(second_side_port_a_i))
    else $error("Main input layout altered");
endmodule : vdd_decim_core

// *** hw/vdd_filt_if.sv ***
// Carrier between the processing core and its chroma decimation filter
`timescale 1ns/1ns
interface vdd_filt_if;
  import vdd_pkg::*;
  vdd_samp_t cb_in;
  vdd_samp_t cr_in;
  logic in_valid;
  logic bypass;
  logic narrow;
  logic decim;
  vdd_samp_t cb_out;
  vdd_samp_t cr_out;
  logic out_strobe;
  modport filt (input cb_in, cr_in, in_valid, bypass, narrow, decim,
                output cb_out, cr_out, out_strobe);
  modport core (output cb_in, cr_in, in_valid, bypass, narrow, decim,
                input cb_out, cr_out, out_strobe);
endinterface : vdd_filt_if

// *** hw/vdd_pkg.sv ***
// Shared constants, types and helpers for the video decimation datapath
package vdd_pkg;
  // Sample widths
  localparam int SAMP_W = 13;
  localparam int KEY_W = 11;
  localparam int COEF_W = 13;
  localparam int COEF_FRAC = 11;
  localparam int NUM_COEF = 10;
  localparam int KEY_IDX = 9;
  localparam logic [12:0] COEF_ONE = 13'h0800;
  localparam logic [12:0] COEF_ZERO = 13'h0000;
  localparam logic [9:0] COEF_UNITY = 10'h311;
  // APB map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COEF = 8'h10;
  localparam logic [7:0] ADDR_KEYC = 8'h34;
  // Control bit positions
  localparam int CTRL_W = 7;
  localparam int CTL_INTERP = 0;
  localparam int CTL_RND = 1;
  localparam int CTL_BYPASS = 2;
  localparam int CTL_FRND = 3;
  localparam int CTL_SYNC = 4;
  localparam int CTL_SSIN = 5;
  localparam int CTL_SINGLE = 6;
  localparam logic [6:0] CTRL_RESET = 7'h20;
  // Latency in clock cycles
  localparam int LAT_DUAL = 68;
  localparam int LAT_SINGLE = 136;
  localparam int PIPE_FIXED = 7;
  localparam int DL_MAX = LAT_SINGLE - PIPE_FIXED + 1;
  localparam logic [7:0] SETTLE_DUAL = 8'(LAT_DUAL);
  localparam logic [7:0] SETTLE_SINGLE = 8'(LAT_SINGLE);
  // Rounding constants
  localparam int MAT_SH_W = COEF_FRAC;
  localparam int MAT_SH_N = COEF_FRAC + 2;
  localparam logic signed [31:0] MAT_HALF_W = 32'sh1 <<< (MAT_SH_W - 1);
  localparam logic signed [31:0] MAT_HALF_N = 32'sh1 <<< (MAT_SH_N - 1);
  localparam int FILT_SH_W = 2;
  localparam int FILT_SH_N = 4;
  localparam logic signed [31:0] FILT_HALF_W = 32'sh2;
  localparam logic signed [31:0] FILT_HALF_N = 32'sh8;
  localparam logic signed [31:0] SAT13_MAX = 32'sh00000fff;
  localparam logic signed [31:0] SAT13_MIN = 32'shfffff000;
  localparam logic signed [31:0] SAT11_MAX = 32'sh000003ff;
  localparam logic signed [31:0] SAT11_MIN = 32'shfffffc00;

  typedef logic signed [SAMP_W-1:0] vdd_samp_t;
  typedef logic signed [KEY_W-1:0] vdd_key_t;
  typedef struct packed {
    logic valid;
    logic strobe;
    vdd_samp_t y;
    vdd_samp_t cb;
    vdd_samp_t cr;
    vdd_key_t key;
  } vdd_word_t;

  function automatic vdd_samp_t vdd_sat13(input logic signed [31:0] v);
    if (v > SAT13_MAX)
      return SAT13_MAX[12:0];
    if (v < SAT13_MIN)
      return SAT13_MIN[12:0];
    return v[12:0];
  endfunction : vdd_sat13

  function automatic vdd_key_t vdd_sat11(input logic signed [31:0] v);
    if (v > SAT11_MAX)
      return SAT11_MAX[10:0];
    if (v < SAT11_MIN)
      return SAT11_MIN[10:0];
    return v[10:0];
  endfunction : vdd_sat11
endpackage : vdd_pkg

// *** testbench/test_video_decimation_datapath.sv ***
// Self-checking bench for the decimation core with a reference model
`timescale 1ns/1ns
module test_video_decimation_datapath;
  import vdd_pkg::*;
  logic clock_i, reset_n_i, psel, penable, pwrite, run, eight, hold;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, rerr, svalid, ov, cs, settled, syncf;
  vdd_samp_t pa, pb, pc, ly, cb, cr;
  vdd_key_t pk, ko;
  int n_errors, checks, cyc, lat, byp, wid, half, nrun, idx, strobes, thru;
  int eb, ec, ei, lastb, lastc;
  int qa[$], qb[$], qc[$], qk[$], qt[$], qi[$];
  // Filter rounding bit 3 stays low in every decimation mode
  logic [6:0] modes [8] = '{7'h24, 7'h20, 7'h30, 7'h64, 7'h26, 7'h22,
                            7'h20, 7'h21};

  vdd_decim_core u_vdd_decim_core (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sample_valid_i(svalid),
    .second_side_port_a_i(pa), .second_side_port_b_i(pb),
    .second_side_port_c_i(pc), .second_side_key_port_i(pk),
    .out_valid_o(ov), .chroma_strobe_o(cs), .luma_o(ly), .chroma_b_o(cb),
    .chroma_r_o(cr), .key_o(ko), .settled_o(settled),
    .sync_flag_output_enable_o(syncf));

  vdd_src_model u_vdd_src_model (.clock_i(clock_i), .run_i(run),
    .eight_bit_i(eight), .hold_chroma_i(hold), .valid_o(svalid), .a_o(pa),
    .b_o(pb), .c_o(pc), .key_o(pk));

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clock_i);
    end
    while (pready !== 1'b1);
    check(pready, 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reference luma: identity or half gain, rounded half up
  function automatic int exp_luma(input int x);
    if (half == 0)
      return x;
    if (wid != 0 && byp != 0)
      return ((x + 4) >>> 3) <<< 2;
    return (x + 1) >>> 1;
  endfunction : exp_luma

  task automatic run_mode(input logic [6:0] ctrl, input int n);
    int wait_n;
    lat = ctrl[6] ? LAT_SINGLE : LAT_DUAL;
    apb(1'b1, ADDR_CTRL, {25'h0, ctrl});
    // Settled drops only one edge after the write lands
    repeat (2) @(posedge clock_i);
    wait_n = 0;
    while (settled !== 1'b1 && wait_n < 400)
    begin
      @(posedge clock_i);
      wait_n++;
    end
    check(wait_n >= lat - 2 && wait_n <= lat + 2, 1'b1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, {25'h0, ctrl});
    check(syncf, ctrl[4]);
    byp = ctrl[2];
    thru = ctrl[2] | ctrl[0];
    wid = ctrl[1];
    nrun = n;
    idx = 0;
    strobes = 0;
    eight <= ctrl[1];
    hold <= !(ctrl[2] | ctrl[0]);
    run <= 1'b1;
    repeat (n) @(posedge clock_i);
    run <= 1'b0;
    repeat (lat + 4) @(posedge clock_i);
    check(qa.size(), 0);
    if (thru == 0)
      check(strobes, n / 2);
  endtask : run_mode

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc >= 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // Downstream side ignores outputs until the core reports settled
  always @(negedge clock_i)
  begin
    if (svalid === 1'b1)
    begin
      qa.push_back(exp_luma(pa));
      // Chroma leaves the filter from its centre tap, one sample late
      qb.push_back(lastb);
      qc.push_back(lastc);
      lastb = pb;
      lastc = pc;
      qk.push_back(pk);
      qt.push_back(cyc);
      qi.push_back(idx);
      idx++;
    end
    if (ov === 1'b1 && settled === 1'b1)
    begin
      check(qa.size() > 0, 1'b1);
      if (qa.size() > 0)
      begin
        check(cyc - qt.pop_front(), lat);
        check(ly, qa.pop_front());
        check(ko, qk.pop_front());
        eb = qb.pop_front();
        ec = qc.pop_front();
        ei = qi.pop_front();
        if (thru != 0)
          check(cs, 1'b1);
        else
          check(cs, ei % 2 == 0);
        if (cs === 1'b1 && ((thru != 0 && ei >= 1)
                            || (ei >= 2 && ei <= nrun - 3)))
        begin
          check(cb, eb);
          check(cr, ec);
        end
        if (cs === 1'b1)
          strobes++;
      end
    end
  end

  initial
  begin
    reset_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    eight = 1'b0;
    hold = 1'b0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    lat = LAT_DUAL;
    half = 0;
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdata, {25'h0, CTRL_RESET});
    apb(1'b0, ADDR_COEF, 32'h0);
    check(rdata, {19'h0, COEF_ONE});
    apb(1'b0, ADDR_COEF + 8'h04, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(rerr, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    check(rerr, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
      begin
        apb(1'b1, ADDR_COEF, 32'h0400);
        half = 1;
      end
      run_mode(modes[i], 24);
    end
    give_verdict();
  end
endmodule : test_video_decimation_datapath

// *** testbench/vdd_src_model.sv ***
// Upstream video source that formats samples to the port bit weighting
`timescale 1ns/1ns
module vdd_src_model
  import vdd_pkg::*;
(
  // Clock and control
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic eight_bit_i,
  input wire logic hold_chroma_i,
  // Sample outputs
  output logic valid_o,
  output vdd_samp_t a_o,
  output vdd_samp_t b_o,
  output vdd_samp_t c_o,
  output vdd_key_t key_o
);
  localparam vdd_samp_t CHROMA_K = 13'h0100;
  logic [63:0] rnd;
  bit seeded;

  initial
  begin
    valid_o = 1'b0;
    a_o = '0;
    b_o = '0;
    c_o = '0;
    key_o = '0;
  end

  always @(posedge clock_i)
  begin
    // Seed this process once, before the first sample is drawn
    if (!seeded)
    begin
      seeded = 1'b1;
      rnd[31:0] = $urandom(32'h646c3dd4);
    end
    rnd = {$urandom, $urandom};
    if (run_i)
    begin
      valid_o <= 1'b1;
      if (eight_bit_i)
      begin
        a_o <= {rnd[10:0], 2'b00};
        b_o <= hold_chroma_i ? CHROMA_K : {rnd[21:11], 2'b00};
        c_o <= hold_chroma_i ? CHROMA_K : {rnd[32:22], 2'b00};
        key_o <= {1'b0, rnd[40:33], 2'b00};
      end
      else
      begin
        a_o <= rnd[12:0];
        b_o <= hold_chroma_i ? CHROMA_K : rnd[25:13];
        c_o <= hold_chroma_i ? CHROMA_K : rnd[38:26];
        key_o <= rnd[49:39];
      end
    end
    else
    begin
      // Idle lines toggle so stale data cannot pass for valid data
      valid_o <= 1'b0;
      a_o <= ~a_o;
      b_o <= ~b_o;
      c_o <= ~c_o;
      key_o <= ~key_o;
    end
  end
endmodule : vdd_src_model
